/* hdl/kbm_defines.svh */
// Constants for the keyboard controller host mailbox
`ifndef KBM_DEFINES_SVH
`define KBM_DEFINES_SVH
`define KBM_ADDR_DATA     8'h60
`define KBM_ADDR_CMD      8'h64
`define KBM_ST_OUT_FULL   0
`define KBM_ST_IN_FULL    1
`define KBM_ST_CMD        3
`define KBM_ST_USER_MASK  8'hf4
`define KBM_STATUS_RST    8'h00
`define KBM_PORT2_RST     8'hcc
`define KBM_PORT1_RST     8'hff
`define KBM_P2_A20        1
`define KBM_P2_MS_DAT     2
`define KBM_P2_MS_CLK     3
`define KBM_P2_KB_IRQ     4
`define KBM_P2_AUX_IRQ    5
`define KBM_P2_KB_CLK     6
`define KBM_P2_KB_DAT     7
`define KBM_STRONG_NS     500
`define KBM_CLK_NS        8
`define KBM_STRONG_CYC    ((`KBM_STRONG_NS + `KBM_CLK_NS - 1) / `KBM_CLK_NS)
`define KBM_ROM_WORDS     2048
`define KBM_RAM_WORDS     256
`define KBM_FIFO_DEPTH    8
`endif

/* hdl/kbm_pkg.sv */
// Types shared by the keyboard controller host mailbox
package kbm_pkg;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} kbm_host_req_t;

	typedef struct packed {
		logic [3:0] user_hi;
		logic       cmd;
		logic       user_lo;
		logic       in_buf_full;
		logic       out_buf_full;
	} kbm_status_t;

	typedef enum logic [2:0] {
		KBM_PD_RUN  = 3'b001,
		KBM_PD_SOFT = 3'b010,
		KBM_PD_HARD = 3'b100
	} kbm_pd_t;
endpackage

/* hdl/kbm_mailbox.sv */
// Keyboard controller host mailbox, port pins, powerdown and memories
`timescale 1ns/10ps
`include "kbm_defines.svh"

module kbm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             i_core_clk,
	input  wire logic             i_rst,
	// Fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// Drain side
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic [AW:0]      count_nxt;
	logic             in_ready_r;
	logic             push;
	logic             pop;

	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;
	// Ready from a flop, so no path runs from the drain side to the filler
	assign o_in_ready  = in_ready_r;
	assign o_out_valid = (count_r != '0);
	assign o_out_data  = mem[rd_ptr_r];

	always_comb
	begin
		count_nxt = count_r;
		if (push && !pop)
			count_nxt = count_r + 1'b1;
		else if (pop && !push)
			count_nxt = count_r - 1'b1;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (push)
			mem[wr_ptr_r] <= i_in_data;
	end

	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
			in_ready_r <= 1'b1;
		end
		else
		begin
			if (push)
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			count_r    <= count_nxt;
			in_ready_r <= (count_nxt != (AW+1)'(DEPTH));
		end
	end
endmodule

module kbm_mailbox (
	// Clock and reset
	input  wire logic                 i_core_clk,
	input  wire logic                 i_rst,
	// Host I/O port
	input  wire kbm_pkg::kbm_host_req_t i_host,
	output logic                      o_host_rvalid,
	output logic [7:0]                o_host_rdata,
	// Controller side of the mailbox
	input  wire logic                 i_mcu_out_valid,
	input  wire logic [7:0]           i_mcu_out_data,
	output logic                      o_mcu_out_ready,
	input  wire logic                 i_mcu_in_rd,
	output logic [7:0]                o_mcu_in_data,
	input  wire logic                 i_mcu_out_full_clr,
	input  wire logic                 i_mcu_user_wr,
	input  wire logic [7:0]           i_mcu_user_data,
	input  wire logic                 i_mcu_en_flags,
	output kbm_pkg::kbm_status_t      o_status,
	// Controller ports
	input  wire logic                 i_p1_wr,
	input  wire logic [7:0]           i_p1_data,
	input  wire logic                 i_p2_wr,
	input  wire logic [7:0]           i_p2_data,
	input  wire logic                 i_open_drain,
	// Host interrupts and A20
	output logic                      o_kbd_irq_out,
	output logic                      o_aux_irq_out,
	output logic                      o_gate_a20,
	// Quasi-bidirectional pins, port1 bits 7, 6, 2
	input  wire logic [2:0]           i_quasi_in,
	output logic [2:0]                o_quasi_out,
	output logic [2:0]                o_quasi_oe,
	// PS/2 pins, open drain
	input  wire logic                 i_kb_clock_pin,
	input  wire logic                 i_kb_data_pin,
	input  wire logic                 i_mouse_clock_pin,
	input  wire logic                 i_mouse_data_pin,
	output logic [3:0]                o_ps2_out,
	output logic [3:0]                o_ps2_oe,
	output logic                      o_test_input_zero,
	output logic                      o_test_input_one,
	output logic                      o_port1_bit0,
	output logic                      o_port1_bit1,
	output logic [2:0]                o_quasi_level,
	// Internal interrupts
	input  wire logic                 i_in_full_int_en,
	input  wire logic                 i_tmr_int_en,
	input  wire logic                 i_tmr_ovf,
	output logic                      o_in_full_irq,
	output logic                      o_tmr_irq,
	// Powerdown
	input  wire logic                 i_mcu_halt,
	input  wire logic                 i_mcu_stop,
	output logic                      o_alu_clk_en,
	output logic                      o_osc_en,
	output logic                      o_resume_call,
	output logic                      o_resume_next,
	// Memories
	input  wire logic                 i_rom_load,
	input  wire logic [10:0]          i_rom_addr,
	input  wire logic [7:0]           i_rom_wdata,
	output logic [7:0]                o_rom_data,
	input  wire logic                 i_ram_wr,
	input  wire logic [7:0]           i_ram_addr,
	input  wire logic [7:0]           i_ram_wdata,
	output logic [7:0]                o_ram_rdata
);
	import kbm_pkg::*;

	localparam logic [6:0] STRONG_CYC = 7'(`KBM_STRONG_CYC);

	function automatic logic addr_hit(input logic [7:0] a,
	                                  input logic [7:0] base);
		addr_hit = (a == base);
	endfunction

	logic [7:0]  in_buf_r;
	logic [7:0]  out_buf_r;
	kbm_status_t status_r;
	logic        en_flags_r;
	logic [7:0]  p1_r;
	logic [7:0]  p2_r;
	logic        host_wr;
	logic        host_rd_data;
	logic        host_rd_cmd;
	logic        fifo_valid;
	logic [7:0]  fifo_data;
	logic        fifo_take;
	logic        out_full_clr;
	logic [6:0]  sync1_r;
	logic [6:0]  sync2_r;
	logic [2:0]  q_bit;
	logic [2:0]  q_prev_r;
	logic [6:0]  q_cnt_r [3];
	kbm_pd_t     pd_r;
	logic [7:0]  rom [`KBM_ROM_WORDS];
	logic [7:0]  ram [`KBM_RAM_WORDS];

	assign host_wr = i_host.wr && (addr_hit(i_host.addr, `KBM_ADDR_DATA) ||
	                 addr_hit(i_host.addr, `KBM_ADDR_CMD));
	assign host_rd_data = i_host.rd && addr_hit(i_host.addr, `KBM_ADDR_DATA);
	assign host_rd_cmd  = i_host.rd && addr_hit(i_host.addr, `KBM_ADDR_CMD);
	// Drain only into an empty output buffer; a load in the same cycle as a clear wins
	assign fifo_take    = fifo_valid && !status_r.out_buf_full;
	assign out_full_clr = (host_rd_data && en_flags_r) ||
	                      i_mcu_out_full_clr;
	assign q_bit     = {p1_r[7], p1_r[6], p1_r[2]};

	// Controller output bytes queue here while the host is slow to read
	kbm_fifo #(
		.WIDTH (8),
		.DEPTH (`KBM_FIFO_DEPTH)
	) u_out_fifo (
		.i_core_clk  (i_core_clk),
		.i_rst       (i_rst),
		.i_in_valid  (i_mcu_out_valid),
		.i_in_data   (i_mcu_out_data),
		.o_in_ready  (o_mcu_out_ready),
		.o_out_valid (fifo_valid),
		.o_out_data  (fifo_data),
		.i_out_ready (!status_r.out_buf_full)
	);

	// Mailbox data buffers
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			in_buf_r      <= 8'h00;
			out_buf_r     <= 8'h00;
			o_mcu_in_data <= 8'h00;
		end
		else
		begin
			if (host_wr)
				in_buf_r <= i_host.wdata;
			if (fifo_take)
				out_buf_r <= fifo_data;
			if (i_mcu_in_rd)
				o_mcu_in_data <= in_buf_r;
		end
	end

	// Status flags; hardware set wins over any clear
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
			status_r <= kbm_status_t'(`KBM_STATUS_RST);
		else
		begin
			if (i_mcu_user_wr)
			begin
				status_r.user_hi <= i_mcu_user_data[7:4];
				status_r.user_lo <= i_mcu_user_data[2];
			end
			if (host_wr)
				status_r.cmd <= i_host.addr[2];
			if (host_wr)
				status_r.in_buf_full <= 1'b1;
			else if (i_mcu_in_rd)
				status_r.in_buf_full <= 1'b0;
			if (fifo_take)
				status_r.out_buf_full <= 1'b1;
			else if (out_full_clr)
				status_r.out_buf_full <= 1'b0;
		end
	end

	// Host read port; status read touches nothing
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_host_rvalid <= 1'b0;
			o_host_rdata  <= 8'h00;
		end
		else
		begin
			o_host_rvalid <= host_rd_data || host_rd_cmd;
			if (host_rd_data)
				o_host_rdata <= out_buf_r;
			else if (host_rd_cmd)
				o_host_rdata <= status_r;
			else
				o_host_rdata <= 8'h00;
		end
	end

	// Flag gating mode and controller ports
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			en_flags_r <= 1'b0;
			p1_r       <= `KBM_PORT1_RST;
			p2_r       <= `KBM_PORT2_RST;
			o_status   <= kbm_status_t'(`KBM_STATUS_RST);
		end
		else
		begin
			if (i_mcu_en_flags)
				en_flags_r <= 1'b1;
			if (i_p1_wr)
				p1_r <= i_p1_data;
			if (i_p2_wr)
				p2_r <= i_p2_data;
			o_status <= status_r;
		end
	end

	// Host interrupt lines and A20 gate
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_kbd_irq_out <= 1'b0;
			o_aux_irq_out <= 1'b0;
			o_gate_a20    <= 1'b0;
		end
		else
		begin
			if (en_flags_r)
			begin
				o_kbd_irq_out <= p2_r[`KBM_P2_KB_IRQ] &&
				                 status_r.out_buf_full;
				o_aux_irq_out <= p2_r[`KBM_P2_AUX_IRQ] &&
				                 !status_r.in_buf_full;
			end
			else
			begin
				o_kbd_irq_out <= p2_r[`KBM_P2_KB_IRQ];
				o_aux_irq_out <= p2_r[`KBM_P2_AUX_IRQ];
			end
			o_gate_a20 <= p2_r[`KBM_P2_A20];
		end
	end

	// Pin inputs pass two flops before use
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
		end
		else
		begin
			sync1_r <= {i_quasi_in, i_mouse_data_pin, i_mouse_clock_pin,
			            i_kb_data_pin, i_kb_clock_pin};
			sync2_r <= sync1_r;
		end
	end

	// PS/2 pins only ever pull low, so the bus stays shareable
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_ps2_out         <= 4'h0;
			o_ps2_oe          <= 4'h0;
			o_test_input_zero <= 1'b0;
			o_port1_bit0      <= 1'b0;
			o_test_input_one  <= 1'b0;
			o_port1_bit1      <= 1'b0;
			o_quasi_level     <= 3'h0;
		end
		else
		begin
			o_ps2_out <= 4'h0;
			o_ps2_oe  <= {p2_r[`KBM_P2_MS_DAT], p2_r[`KBM_P2_MS_CLK],
			              p2_r[`KBM_P2_KB_DAT], p2_r[`KBM_P2_KB_CLK]};
			o_test_input_zero <= sync2_r[0];
			o_port1_bit0      <= sync2_r[1];
			o_test_input_one  <= sync2_r[2];
			o_port1_bit1      <= sync2_r[3];
			o_quasi_level     <= sync2_r[6:4];
		end
	end

	// Quasi pins: no input or invert path exists to configure
	for (genvar g = 0; g < 3; g++)
	begin : g_quasi
		always_ff @(posedge i_core_clk or posedge i_rst)
		begin
			if (i_rst)
			begin
				q_prev_r[g]    <= 1'b1;
				q_cnt_r[g]     <= 7'h00;
				o_quasi_out[g] <= 1'b1;
				o_quasi_oe[g]  <= 1'b0;
			end
			else
			begin
				q_prev_r[g] <= q_bit[g];
				if (q_bit[g] && !q_prev_r[g] && !i_open_drain)
					q_cnt_r[g] <= STRONG_CYC;
				else if (q_cnt_r[g] != 7'h00)
					q_cnt_r[g] <= q_cnt_r[g] - 7'h01;
				o_quasi_out[g] <= q_bit[g];
				if (!q_bit[g])
					o_quasi_oe[g] <= 1'b1;
				else if (i_open_drain)
					o_quasi_oe[g] <= 1'b0;
				else
					o_quasi_oe[g] <= (q_cnt_r[g] > 7'h01) ||
					                 (q_bit[g] && !q_prev_r[g]);
			end
		end
	end

	// Powerdown; reset restarts the core at address zero outside
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			pd_r          <= KBM_PD_RUN;
			o_alu_clk_en  <= 1'b1;
			o_osc_en      <= 1'b1;
			o_resume_call <= 1'b0;
			o_resume_next <= 1'b0;
		end
		else
		begin
			o_resume_call <= 1'b0;
			o_resume_next <= 1'b0;
			unique case (pd_r)
				KBM_PD_RUN:
				begin
					if (i_mcu_stop)
						pd_r <= KBM_PD_HARD;
					else if (i_mcu_halt)
						pd_r <= KBM_PD_SOFT;
				end
				KBM_PD_SOFT, KBM_PD_HARD:
				begin
					if (host_wr)
					begin
						pd_r          <= KBM_PD_RUN;
						o_resume_call <= i_in_full_int_en;
						o_resume_next <= !i_in_full_int_en;
					end
				end
				default:
					pd_r <= KBM_PD_RUN;
			endcase
			o_alu_clk_en <= (pd_r == KBM_PD_RUN) || host_wr;
			o_osc_en     <= (pd_r != KBM_PD_HARD) || host_wr;
		end
	end

	// Only the two internal interrupt sources exist
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_in_full_irq <= 1'b0;
			o_tmr_irq     <= 1'b0;
		end
		else
		begin
			o_in_full_irq <= status_r.in_buf_full &&
			                 i_in_full_int_en;
			o_tmr_irq <= i_tmr_ovf && i_tmr_int_en;
		end
	end

	// Program memory is loaded by the image port, not preset
	always_ff @(posedge i_core_clk)
	begin
		if (i_rom_load)
			rom[i_rom_addr] <= i_rom_wdata;
		o_rom_data <= rom[i_rom_addr];
		if (i_ram_wr)
			ram[i_ram_addr] <= i_ram_wdata;
		o_ram_rdata <= ram[i_ram_addr];
	end
endmodule

/* test/kbm_mailbox_asserts.sv */
// Port checks for the host mailbox
`timescale 1ns/10ps
`include "kbm_defines.svh"
module kbm_mailbox_asserts (
	// Clock and reset
	input wire logic                   i_core_clk,
	input wire logic                   i_rst,
	// Watched inputs
	input wire kbm_pkg::kbm_host_req_t i_host,
	input wire logic                   i_mcu_en_flags,
	input wire logic                   i_p2_wr,
	input wire logic [7:0]             i_p2_data,
	input wire logic                   i_open_drain,
	input wire logic                   i_mcu_halt,
	input wire logic                   i_mcu_stop,
	// Watched outputs
	input wire logic                   o_host_rvalid,
	input wire kbm_pkg::kbm_status_t   o_status,
	input wire logic                   o_kbd_irq_out,
	input wire logic                   o_aux_irq_out,
	input wire logic [2:0]             o_quasi_out,
	input wire logic [2:0]             o_quasi_oe,
	input wire logic [3:0]             o_ps2_oe,
	input wire logic                   o_alu_clk_en,
	input wire logic                   o_osc_en
);
	import kbm_pkg::*;
	logic       gated_r;
	logic [7:0] p2_r;
	logic [6:0] hi_cnt_r;
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
			gated_r <= 1'b0;
		else if (i_mcu_en_flags)
			gated_r <= 1'b1;
	end
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
			p2_r <= `KBM_PORT2_RST;
		else if (i_p2_wr)
			p2_r <= i_p2_data;
	end
	// Length of the current strong-high drive on quasi bit 0
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
			hi_cnt_r <= 7'h00;
		else if (o_quasi_oe[0] && o_quasi_out[0])
			hi_cnt_r <= hi_cnt_r + 7'h01;
		else
			hi_cnt_r <= 7'h00;
	end
	sequence s_wr(logic [7:0] a);
		i_host.wr && i_host.addr == a;
	endsequence
	sequence s_rd_map;
		i_host.rd && (i_host.addr == `KBM_ADDR_DATA ||
			i_host.addr == `KBM_ADDR_CMD);
	endsequence
	a_data_write: assert property (s_wr(`KBM_ADDR_DATA) |->
		##[1:2] (o_status.in_buf_full && !o_status.cmd))
		else $error("data write");
	a_cmd_write: assert property (s_wr(`KBM_ADDR_CMD) |->
		##[1:2] (o_status.in_buf_full && o_status.cmd))
		else $error("cmd write");
	a_read_answer: assert property (s_rd_map |=> o_host_rvalid)
		else $error("no read answer");
	a_unmapped_quiet: assert property (i_host.rd && !i_host.wr &&
		i_host.addr != `KBM_ADDR_DATA && i_host.addr != `KBM_ADDR_CMD
		|=> !o_host_rvalid) else $error("unmapped answered");
	a_kbd_irq_out_reset: assert property (disable iff (1'b0)
		i_rst |=> !o_kbd_irq_out) else $error("kbd irq after reset");
	a_ungated_irq: assert property ((!gated_r && $stable(p2_r)) [*2] |->
		o_kbd_irq_out == p2_r[4] && o_aux_irq_out == p2_r[5])
		else $error("ungated irq");
	a_gated_low: assert property ((gated_r && !p2_r[4]) [*2] |->
		!o_kbd_irq_out) else $error("gated kbd irq");
	a_gated_aux: assert property ((gated_r && p2_r[5] &&
		$stable(o_status.in_buf_full)) [*3] |->
		o_aux_irq_out == !o_status.in_buf_full)
		else $error("gated aux irq");
	a_ps2_map: assert property ($stable(p2_r) [*2] |->
		o_ps2_oe == {p2_r[2], p2_r[3], p2_r[7], p2_r[6]})
		else $error("ps2 enables");
	a_strong_bound: assert property (hi_cnt_r <= `KBM_STRONG_CYC)
		else $error("strong drive too long");
	a_open_drain: assert property (i_open_drain && $past(i_open_drain)
		|-> !(o_quasi_oe[0] && o_quasi_out[0])) else $error("drove high");
	a_soft_down: assert property (i_mcu_halt && !i_mcu_stop &&
		o_alu_clk_en && !i_host.wr |-> ##2 (!o_alu_clk_en && o_osc_en))
		else $error("soft powerdown");
	a_hard_down: assert property (i_mcu_stop && o_alu_clk_en &&
		!i_host.wr |-> ##2 !o_osc_en) else $error("hard powerdown");
endmodule
bind kbm_mailbox kbm_mailbox_asserts i_chk (.*);

/* test/kbm_host_model.sv */
// Host processor model for the mailbox I/O port
`timescale 1ns/10ps
module kbm_host_model (
	// Clock
	input  wire logic              i_core_clk,
	// Mailbox I/O port
	output kbm_pkg::kbm_host_req_t o_host,
	input  wire logic              i_rvalid,
	input  wire logic [7:0]        i_rdata
);
	import kbm_pkg::*;
	initial o_host = '0;
	// Idle bus shows inverted address and data, never the last values
	task automatic host_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		#1;
		o_host = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_core_clk);
		#1;
		o_host = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic host_read(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(posedge i_core_clk);
		#1;
		o_host = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge i_core_clk);
		#1;
		o_host = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
		repeat (3)
		begin
			if (!ok && i_rvalid === 1'b1)
			begin
				ok = 1'b1;
				d = i_rdata;
			end
			@(posedge i_core_clk);
			#1;
		end
	endtask
endmodule

/* test/testbench.sv */
// Self-checking bench for the host mailbox
`timescale 1ns/10ps
`include "kbm_defines.svh"
`define CHK(got, exp) \
	begin \
		n_checks++; \
		if ((got) !== (exp)) \
		begin \
			error_cnt++; \
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
		end \
	end
module testbench;
	import kbm_pkg::*;
	logic i_core_clk = 1'b0, i_rst = 1'b1, o_host_rvalid, i_mcu_out_valid;
	logic o_mcu_out_ready, i_mcu_in_rd, i_mcu_out_full_clr, i_mcu_user_wr;
	logic i_mcu_en_flags, i_p1_wr, i_p2_wr, i_open_drain, o_kbd_irq_out;
	logic o_aux_irq_out, o_gate_a20, o_test_input_zero, o_test_input_one;
	logic o_port1_bit0, o_port1_bit1, i_in_full_int_en, i_tmr_int_en;
	logic i_tmr_ovf, o_in_full_irq, o_tmr_irq, i_mcu_halt, i_mcu_stop;
	logic o_alu_clk_en;
	logic o_osc_en, o_resume_call, o_resume_next, i_rom_load, i_ram_wr;
	logic i_kb_clock_pin, i_kb_data_pin, i_mouse_clock_pin, i_mouse_data_pin;
	logic [7:0] o_host_rdata, i_mcu_out_data, o_mcu_in_data;
	logic [7:0] i_mcu_user_data;
	logic [7:0] i_p1_data, i_p2_data, i_rom_wdata, o_rom_data, i_ram_addr;
	logic [7:0] i_ram_wdata, o_ram_rdata;
	logic [2:0] i_quasi_in, o_quasi_out, o_quasi_oe, o_quasi_level;
	logic [3:0] o_ps2_out, o_ps2_oe;
	logic [10:0] i_rom_addr;
	kbm_host_req_t i_host;
	kbm_status_t o_status;
	int error_cnt = 0, n_checks = 0, cyc = 0;
	// Pins float to their pull-ups unless driven
	assign i_quasi_in = (o_quasi_oe & o_quasi_out) | ~o_quasi_oe;
	assign {i_mouse_data_pin, i_mouse_clock_pin, i_kb_data_pin,
		i_kb_clock_pin} = (o_ps2_oe & o_ps2_out) | ~o_ps2_oe;
	kbm_mailbox i_dut (.*);
	kbm_host_model i_host_m (.i_core_clk(i_core_clk), .o_host(i_host),
		.i_rvalid(o_host_rvalid), .i_rdata(o_host_rdata));
	always #4 i_core_clk = ~i_core_clk;
	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge i_core_clk);
			#1;
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask
	task automatic push(input logic [7:0] d);
		i_mcu_out_data = d;
		pulse(i_mcu_out_valid);
		tick(4);
	endtask
	task automatic do_reset();
		i_rst = 1'b1;
		tick(3);
		i_rst = 1'b0;
	endtask
	task automatic t_reset_state();
		tick(5);
		`CHK(o_status, 8'h00)
		`CHK(o_kbd_irq_out, 1'b0)
		`CHK({o_ps2_oe, o_test_input_zero, o_port1_bit1}, 6'h3c)
	endtask
	task automatic t_host_port();
		logic [7:0] d;
		logic       ok;
		for (int k = 0; k < 2; k++)
		begin
			i_host_m.host_write(k ? `KBM_ADDR_CMD : `KBM_ADDR_DATA, 8'h5a ^ k[7:0]);
			tick(2);
			`CHK(o_status[3:1], {k[0], 2'b01})
			i_host_m.host_read(`KBM_ADDR_CMD, d, ok);
			`CHK({ok, d}, {1'b1, 4'h0, k[0], 3'h2})
			`CHK(o_status.in_buf_full, 1'b1)
			pulse(i_mcu_in_rd);
			`CHK(o_mcu_in_data, 8'h5a ^ k[7:0])
			tick(2);
			`CHK(o_status.in_buf_full, 1'b0)
		end
		i_host_m.host_read(8'h61, d, ok);
		`CHK(ok, 1'b0)
	endtask
	task automatic t_out_stream();
		logic [7:0] d;
		logic       ok;
		int         n;
		n = 0;
		i_mcu_out_valid = 1'b1;
		i_mcu_out_data = 8'h20;
		while (o_mcu_out_ready === 1'b1 && n < 16)
		begin
			tick(1);
			n++;
			i_mcu_out_data = 8'h20 + n[7:0];
		end
		i_mcu_out_valid = 1'b0;
		`CHK(n >= `KBM_FIFO_DEPTH, 1'b1)
		tick(2);
		`CHK(o_status.out_buf_full, 1'b1)
		for (int k = 0; k < n; k++)
		begin
			i_host_m.host_read(`KBM_ADDR_DATA, d, ok);
			`CHK(d, 8'h20 + k[7:0])
			`CHK(o_status.out_buf_full, 1'b1)
			pulse(i_mcu_out_full_clr);
			tick(3);
		end
		`CHK({o_status.out_buf_full, o_mcu_out_ready}, 2'b01)
	endtask
	task automatic t_ungated();
		logic [7:0] v;
		for (int k = 0; k < 3; k++)
		begin
			v = k == 0 ? 8'h32 : k == 1 ? 8'hcd : 8'h30;
			i_p2_data = v;
			pulse(i_p2_wr);
			tick(5);
			`CHK({o_kbd_irq_out, o_aux_irq_out}, {v[4], v[5]})
			`CHK(o_gate_a20, v[1])
			`CHK(o_ps2_oe, {v[2], v[3], v[7], v[6]})
			`CHK(o_ps2_out, 4'h0)
			`CHK({o_port1_bit1, o_test_input_one, o_port1_bit0,
				o_test_input_zero}, ~{v[2], v[3], v[7], v[6]})
		end
	endtask
	task automatic t_gated();
		logic [7:0] d;
		logic       ok;
		pulse(i_mcu_en_flags);
		tick(2);
		`CHK({o_kbd_irq_out, o_aux_irq_out}, 2'b01)
		push(8'h77);
		`CHK(o_kbd_irq_out, 1'b1)
		i_host_m.host_read(`KBM_ADDR_DATA, d, ok);
		tick(2);
		`CHK({d, o_status.out_buf_full, o_kbd_irq_out}, 10'h1dc)
		i_host_m.host_write(`KBM_ADDR_DATA, 8'h11);
		tick(2);
		`CHK(o_aux_irq_out, 1'b0)
		pulse(i_mcu_in_rd);
		tick(2);
		`CHK(o_aux_irq_out, 1'b1)
		i_p2_data = 8'h20;
		pulse(i_p2_wr);
		push(8'h88);
		`CHK({o_status.out_buf_full, o_kbd_irq_out}, 2'b10)
	endtask
	task automatic t_quasi();
		int n;
		for (int m = 0; m < 2; m++)
		begin
			i_open_drain = m[0];
			i_p1_data = 8'h3b;
			pulse(i_p1_wr);
			tick(5);
			`CHK({o_quasi_oe, o_quasi_out, o_quasi_level}, 9'h1c0)
			i_p1_data = 8'hff;
			pulse(i_p1_wr);
			n = 0;
			repeat (80)
			begin
				n += int'(o_quasi_oe[0] && o_quasi_out[0]);
				tick(1);
			end
			`CHK(n, m ? 0 : `KBM_STRONG_CYC)
			`CHK({o_quasi_oe, o_quasi_level}, 6'h07)
		end
		i_open_drain = 1'b0;
	endtask
	task automatic t_power();
		logic [1:0] seen;
		for (int m = 0; m < 2; m++)
		begin
			i_in_full_int_en = ~m[0];
			if (m == 0)
				pulse(i_mcu_halt);
			else
				pulse(i_mcu_stop);
			tick(2);
			`CHK({o_alu_clk_en, o_osc_en}, {1'b0, ~m[0]})
			i_host_m.host_write(`KBM_ADDR_DATA, 8'h42);
			seen = 2'b00;
			repeat (4)
			begin
				seen |= {o_resume_call, o_resume_next};
				tick(1);
			end
			`CHK(seen, m ? 2'b01 : 2'b10)
			`CHK({o_alu_clk_en, o_osc_en, o_in_full_irq}, {2'b11, ~m[0]})
			pulse(i_mcu_in_rd);
		end
		i_tmr_int_en = 1'b1;
		pulse(i_tmr_ovf);
		`CHK(o_tmr_irq, 1'b1)
	endtask
	task automatic t_misc();
		i_rom_addr = 11'h7ff;
		i_rom_wdata = 8'hc3;
		pulse(i_rom_load);
		i_ram_addr = 8'hff;
		i_ram_wdata = 8'h3c;
		pulse(i_ram_wr);
		tick(2);
		`CHK({o_rom_data, o_ram_rdata}, 16'hc33c)
		i_mcu_user_data = 8'hff;
		pulse(i_mcu_user_wr);
		tick(2);
		`CHK(o_status & 8'hf4, 8'hf4)
	endtask
	task automatic complete_run();
		if (error_cnt == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge i_core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			complete_run();
		end
	end
	initial
	begin
		{i_mcu_out_valid, i_mcu_in_rd, i_mcu_out_full_clr, i_mcu_user_wr} = '0;
		{i_mcu_en_flags, i_p1_wr, i_p2_wr, i_open_drain, i_tmr_ovf} = '0;
		{i_in_full_int_en, i_tmr_int_en, i_mcu_halt, i_mcu_stop} = '0;
		{i_rom_load, i_ram_wr, i_mcu_out_data, i_mcu_user_data} = '0;
		{i_p1_data, i_p2_data, i_rom_wdata, i_ram_addr} = '0;
		{i_ram_wdata, i_rom_addr} = '0;
		do_reset();
		t_reset_state();
		t_host_port();
		t_out_stream();
		t_ungated();
		t_gated();
		t_quasi();
		t_power();
		t_misc();
		do_reset();
		t_reset_state();
		complete_run();
	end
endmodule
